// file: core/ctes_pkg.sv
// Shared constants and types of the trigger and exposure sequencer
package ctes_pkg;

    // ---------------------------------------------------------------
    // Widths
    // ---------------------------------------------------------------
    localparam int CNT_W = 32;
    localparam int FPE_W = 16;

    // ---------------------------------------------------------------
    // Host configuration encodings
    // ---------------------------------------------------------------
    localparam logic [1:0] EVT_NONE     = 2'h0;
    localparam logic [1:0] EVT_STANDARD = 2'h1;
    localparam logic [1:0] EVT_LEVEL    = 2'h2;
    localparam logic       EDGE_FALLING = 1'h0;
    localparam logic       EDGE_RISING  = 1'h1;

    // ---------------------------------------------------------------
    // Counts and reset values
    // ---------------------------------------------------------------
    localparam logic [FPE_W-1:0] FPE_ZERO      = 16'h0000;
    localparam logic [FPE_W-1:0] FPE_ONE       = 16'h0001;
    localparam logic [CNT_W-1:0] CNT_ZERO      = 32'h00000000;
    localparam logic [CNT_W-1:0] CNT_ONE       = 32'h00000001;
    localparam logic             EDGE_PREV_RST = 1'h1;

    // ---------------------------------------------------------------
    // State and mode types
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        S_IDLE    = 2'b00,
        S_EXPOSE  = 2'b01,
        S_READOUT = 2'b10,
        S_WAIT    = 2'b11
    } ctes_state_t;

    typedef enum logic [1:0] {
        MODE_SW     = 2'b00,
        MODE_STREAM = 2'b01,
        MODE_ASYNC  = 2'b10,
        MODE_LEVEL  = 2'b11
    } ctes_mode_t;

endpackage

// file: core/ctes_edge.sv
// Trigger polarity and edge detection
`timescale 1ns/1ps
`default_nettype none
module ctes_edge (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic resetn,
    // Trigger and polarity
    input  wire logic trigger_in,
    input  wire logic external_event_edge_select,
    // Detected events
    output logic      trig_active,
    output logic      trig_assert,
    output logic      trig_deassert
);
    typedef struct packed {
        logic prev;
    } ctes_edge_t;

    ctes_edge_t e_reg;
    ctes_edge_t e_next;

    // Previous level resets as active so a held line gives no false start
    always_comb begin
        trig_active = (external_event_edge_select == ctes_pkg::EDGE_RISING) ?
                      trigger_in : ~trigger_in;
        e_next        = e_reg;
        e_next.prev   = trig_active;
        trig_assert   = trig_active & ~e_reg.prev;
        trig_deassert = ~trig_active & e_reg.prev;
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            e_reg.prev <= ctes_pkg::EDGE_PREV_RST;
        end else begin
            e_reg <= e_next;
        end
    end
endmodule
`default_nettype wire

// file: core/ctes_timer.sv
// Loadable down counter that flags its last cycle
`timescale 1ns/1ps
`default_nettype none
module ctes_timer (
    // Clock and reset
    input  wire logic                      clk_sys,
    input  wire logic                      resetn,
    // Control
    input  wire logic                      load,
    input  wire logic [ctes_pkg::CNT_W-1:0] value,
    // Status
    output logic                           last
);
    typedef struct packed {
        logic [ctes_pkg::CNT_W-1:0] cnt;
    } ctes_timer_t;

    ctes_timer_t t_reg;
    ctes_timer_t t_next;

    // A zero length is stretched to one cycle
    always_comb begin
        t_next = t_reg;
        if (load) begin
            t_next.cnt = (value == ctes_pkg::CNT_ZERO) ? ctes_pkg::CNT_ONE : value;
        end else if (t_reg.cnt != ctes_pkg::CNT_ZERO) begin
            t_next.cnt = t_reg.cnt - ctes_pkg::CNT_ONE;
        end
        last = (t_reg.cnt <= ctes_pkg::CNT_ONE);
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            t_reg.cnt <= ctes_pkg::CNT_ZERO;
        end else begin
            t_reg <= t_next;
        end
    end
endmodule
`default_nettype wire

// file: core/ctes_seq.sv
// Trigger and exposure sequencer: mode decode, frame state machine, strobe
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// What this block does
// - Streaming, asynchronous and level-timed hardware modes
// - Trigger logic ignores readout rate and gain
// - Streaming trigger starts timed exposure, then readout
// - Streaming repeats at frame interval without triggers
// - Streaming ignores further triggers until halted
// - Async trigger gives one timed exposure, one readout
// - Async ignores triggers during readout
// - Async waits idle for a new trigger
// - Level mode exposes while trigger stays active
// - Level mode ignores trigger edges during readout
// - Exposure output high throughout every exposure
// - Software capture takes exactly frames-per-event frames
// - Standard trigger, count not one: streaming
// - Standard trigger, count one: asynchronous
// - Pulse-driven setting selects level-timed mode
// - Polarity chooses rising or falling start edge
// ---------------------------------------------------------------
module ctes_seq (
    // Clock and reset
    input  wire logic                       clk_sys,
    input  wire logic                       resetn,
    // Host configuration
    input  wire logic [1:0]                 external_event_mode_select,
    input  wire logic                       external_event_edge_select,
    input  wire logic [ctes_pkg::FPE_W-1:0] frames_per_event,
    input  wire logic [ctes_pkg::CNT_W-1:0] exposure_cycles,
    input  wire logic [ctes_pkg::CNT_W-1:0] frame_interval_cycles,
    // Host commands
    input  wire logic                       capture_start,
    input  wire logic                       acquisition_halt,
    // Trigger pin
    input  wire logic                       trigger_in,
    // Readout engine
    input  wire logic                       readout_done,
    output logic                            readout_start,
    // Strobe pin
    output logic                            exposure_active,
    // Status
    output logic                            acquisition_busy,
    output logic                            trigger_ignored,
    output logic [ctes_pkg::FPE_W-1:0]      frame_count,
    output logic [1:0]                      active_mode
);
    typedef struct packed {
        ctes_pkg::ctes_state_t      state;
        ctes_pkg::ctes_mode_t       mode;
        logic [ctes_pkg::FPE_W-1:0] frames_left;
        logic [ctes_pkg::FPE_W-1:0] frame_count;
        logic                       strobe;
        logic                       ro_start;
        logic                       ignored;
    } ctes_seq_t;

    ctes_seq_t            s_reg;
    ctes_seq_t            s_next;
    ctes_pkg::ctes_mode_t cfg_mode;
    logic                 trig_active;
    logic                 trig_assert;
    logic                 trig_deassert;
    logic                 exp_load;
    logic                 exp_last;
    logic                 ivl_last;

    // ---------------------------------------------------------------
    // Trigger edge and timers
    // ---------------------------------------------------------------
    ctes_edge u_edge (
        .clk_sys                    (clk_sys),
        .resetn                     (resetn),
        .trigger_in                 (trigger_in),
        .external_event_edge_select (external_event_edge_select),
        .trig_active                (trig_active),
        .trig_assert                (trig_assert),
        .trig_deassert              (trig_deassert)
    );

    ctes_timer u_exp_timer (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .load    (exp_load),
        .value   (exposure_cycles),
        .last    (exp_last)
    );

    // Interval runs from exposure start, so readout time falls inside the same period
    ctes_timer u_ivl_timer (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .load    (exp_load),
        .value   (frame_interval_cycles),
        .last    (ivl_last)
    );

    // ---------------------------------------------------------------
    // Mode decode
    // ---------------------------------------------------------------
    // Readout rate, binning and gain never enter here
    always_comb begin
        if (external_event_mode_select == ctes_pkg::EVT_LEVEL) begin
            cfg_mode = ctes_pkg::MODE_LEVEL;
        end else if (external_event_mode_select == ctes_pkg::EVT_STANDARD) begin
            if (frames_per_event == ctes_pkg::FPE_ONE) begin
                cfg_mode = ctes_pkg::MODE_ASYNC;
            end else begin
                cfg_mode = ctes_pkg::MODE_STREAM;
            end
        end else begin
            cfg_mode = ctes_pkg::MODE_SW;
        end
    end

    // ---------------------------------------------------------------
    // Frame state machine
    // ---------------------------------------------------------------
    always_comb begin
        s_next          = s_reg;
        exp_load        = 1'b0;
        s_next.ro_start = 1'b0;
        s_next.ignored  = 1'b0;
        case (s_reg.state)
            ctes_pkg::S_IDLE: begin
                if (acquisition_halt) begin
                    s_next.state = ctes_pkg::S_IDLE;
                end else if (cfg_mode == ctes_pkg::MODE_SW) begin
                    // Trigger pin plays no part in software capture
                    if (capture_start && frames_per_event != ctes_pkg::FPE_ZERO) begin
                        s_next.state       = ctes_pkg::S_EXPOSE;
                        s_next.mode        = cfg_mode;
                        s_next.frames_left = frames_per_event;
                        s_next.frame_count = ctes_pkg::FPE_ZERO;
                        exp_load           = 1'b1;
                    end
                end else if (trig_assert) begin
                    s_next.state       = ctes_pkg::S_EXPOSE;
                    s_next.mode        = cfg_mode;
                    s_next.frame_count = ctes_pkg::FPE_ZERO;
                    exp_load           = 1'b1;
                end
            end
            ctes_pkg::S_EXPOSE: begin
                s_next.ignored = trig_assert;
                if (acquisition_halt) begin
                    s_next.state = ctes_pkg::S_IDLE;
                end else if (s_reg.mode == ctes_pkg::MODE_LEVEL) begin
                    if (trig_deassert) begin
                        s_next.state       = ctes_pkg::S_READOUT;
                        s_next.ro_start    = 1'b1;
                        s_next.frame_count = s_reg.frame_count + ctes_pkg::FPE_ONE;
                    end
                end else if (exp_last) begin
                    s_next.state       = ctes_pkg::S_READOUT;
                    s_next.ro_start    = 1'b1;
                    s_next.frame_count = s_reg.frame_count + ctes_pkg::FPE_ONE;
                end
            end
            ctes_pkg::S_READOUT: begin
                // Edges seen here are dropped, never queued
                s_next.ignored = trig_assert;
                if (acquisition_halt) begin
                    s_next.state = ctes_pkg::S_IDLE;
                end else if (readout_done) begin
                    case (s_reg.mode)
                        ctes_pkg::MODE_STREAM: begin
                            s_next.state = ctes_pkg::S_WAIT;
                        end
                        ctes_pkg::MODE_SW: begin
                            if (s_reg.frames_left == ctes_pkg::FPE_ONE) begin
                                s_next.state = ctes_pkg::S_IDLE;
                            end else begin
                                s_next.state       = ctes_pkg::S_WAIT;
                                s_next.frames_left = s_reg.frames_left - ctes_pkg::FPE_ONE;
                            end
                        end
                        default: begin
                            s_next.state = ctes_pkg::S_IDLE;
                        end
                    endcase
                end
            end
            ctes_pkg::S_WAIT: begin
                s_next.ignored = trig_assert;
                if (acquisition_halt) begin
                    s_next.state = ctes_pkg::S_IDLE;
                end else if (ivl_last) begin
                    s_next.state = ctes_pkg::S_EXPOSE;
                    exp_load     = 1'b1;
                end
            end
            default: begin
                s_next.state = ctes_pkg::S_IDLE;
            end
        endcase
        s_next.strobe = (s_next.state == ctes_pkg::S_EXPOSE);
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            s_reg.state       <= ctes_pkg::S_IDLE;
            s_reg.mode        <= ctes_pkg::MODE_SW;
            s_reg.frames_left <= ctes_pkg::FPE_ZERO;
            s_reg.frame_count <= ctes_pkg::FPE_ZERO;
            s_reg.strobe      <= 1'b0;
            s_reg.ro_start    <= 1'b0;
            s_reg.ignored     <= 1'b0;
        end else begin
            s_reg <= s_next;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign exposure_active  = s_reg.strobe;
    assign readout_start    = s_reg.ro_start;
    assign trigger_ignored  = s_reg.ignored;
    assign frame_count      = s_reg.frame_count;
    assign active_mode      = s_reg.mode;
    assign acquisition_busy = (s_reg.state != ctes_pkg::S_IDLE);

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    logic [ctes_pkg::CNT_W-1:0] chk_exp_len;
    logic [ctes_pkg::CNT_W-1:0] chk_exp_want;
    logic [ctes_pkg::FPE_W-1:0] chk_fpe;

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            chk_exp_len  <= ctes_pkg::CNT_ZERO;
            chk_exp_want <= ctes_pkg::CNT_ONE;
            chk_fpe      <= ctes_pkg::FPE_ZERO;
        end else if (exp_load) begin
            chk_exp_len  <= ctes_pkg::CNT_ONE;
            chk_exp_want <= (exposure_cycles == ctes_pkg::CNT_ZERO) ?
                            ctes_pkg::CNT_ONE : exposure_cycles;
            if (s_reg.state == ctes_pkg::S_IDLE) begin
                chk_fpe <= frames_per_event;
            end
        end else if (s_reg.state == ctes_pkg::S_EXPOSE) begin
            chk_exp_len <= chk_exp_len + ctes_pkg::CNT_ONE;
        end
    end

    default clocking chk_cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    exp_length_a : assert property (
        (s_reg.state == ctes_pkg::S_EXPOSE && s_reg.mode != ctes_pkg::MODE_LEVEL
         && !acquisition_halt && exp_last)
        |-> chk_exp_len == chk_exp_want)
        else $error("timed exposure length differs from programmed count");

    readout_follows_a : assert property (
        $fell(exposure_active) && !$past(acquisition_halt)
        |-> readout_start && s_reg.state == ctes_pkg::S_READOUT)
        else $error("exposure end without readout start");

    strobe_state_a : assert property (
        $rose(s_reg.state == ctes_pkg::S_EXPOSE) |-> exposure_active
        ##1 (exposure_active == (s_reg.state == ctes_pkg::S_EXPOSE)))
        else $error("strobe does not track exposure");

    stream_repeat_a : assert property (
        s_reg.state == ctes_pkg::S_WAIT && ivl_last && !acquisition_halt
        |=> exposure_active && acquisition_busy)
        else $error("streaming did not restart exposure at interval");

    stream_holds_a : assert property (
        acquisition_busy && s_reg.mode == ctes_pkg::MODE_STREAM && !acquisition_halt
        |=> acquisition_busy && s_reg.mode == ctes_pkg::MODE_STREAM)
        else $error("streaming stopped without halt");

    async_readout_a : assert property (
        s_reg.state == ctes_pkg::S_READOUT && s_reg.mode == ctes_pkg::MODE_ASYNC
        && !readout_done && !acquisition_halt
        |=> s_reg.state == ctes_pkg::S_READOUT && !exposure_active)
        else $error("asynchronous readout disturbed by trigger");

    async_idle_a : assert property (
        s_reg.state == ctes_pkg::S_READOUT && s_reg.mode == ctes_pkg::MODE_ASYNC
        && readout_done
        |=> !acquisition_busy ##1 (!exposure_active || $past(trig_assert)))
        else $error("asynchronous mode did not return to idle");

    level_start_a : assert property (
        !acquisition_busy && cfg_mode == ctes_pkg::MODE_LEVEL && trig_assert
        && !acquisition_halt
        |=> exposure_active && active_mode == ctes_pkg::MODE_LEVEL)
        else $error("level mode did not open exposure on trigger");

    level_end_a : assert property (
        s_reg.state == ctes_pkg::S_EXPOSE && s_reg.mode == ctes_pkg::MODE_LEVEL
        && trig_deassert && !acquisition_halt
        |=> !exposure_active && readout_start)
        else $error("level mode did not close exposure on release");

    level_ignore_a : assert property (
        s_reg.state == ctes_pkg::S_READOUT && s_reg.mode == ctes_pkg::MODE_LEVEL
        && !readout_done
        |=> !exposure_active)
        else $error("level mode exposure during readout");

    polarity_a : assert property (
        external_event_edge_select == ctes_pkg::EDGE_RISING
        |-> trig_active == trigger_in)
        else $error("trigger polarity decode wrong");

    sw_no_trigger_a : assert property (
        !acquisition_busy && cfg_mode == ctes_pkg::MODE_SW && !capture_start
        |=> !acquisition_busy)
        else $error("software mode started without capture command");

    sw_frames_a : assert property (
        s_reg.state == ctes_pkg::S_READOUT && s_reg.mode == ctes_pkg::MODE_SW
        && readout_done && s_reg.frames_left == ctes_pkg::FPE_ONE
        |-> frame_count == chk_fpe)
        else $error("software capture frame count wrong");

    mode_decode_a : assert property (
        external_event_mode_select == ctes_pkg::EVT_STANDARD
        && frames_per_event == ctes_pkg::FPE_ONE
        |-> cfg_mode == ctes_pkg::MODE_ASYNC)
        else $error("single frame standard trigger not asynchronous");

    stream_cover_c : cover property (
        s_reg.mode == ctes_pkg::MODE_STREAM && s_reg.frame_count == 16'h0003);
    async_cover_c : cover property (
        s_reg.mode == ctes_pkg::MODE_ASYNC && trigger_ignored);
    level_cover_c : cover property (
        s_reg.mode == ctes_pkg::MODE_LEVEL && $fell(exposure_active));
    sw_cover_c : cover property (
        s_reg.mode == ctes_pkg::MODE_SW && $fell(acquisition_busy));
endmodule
`default_nettype wire

// file: sim/ctes_far.sv
// Far-side model: external trigger source and readout engine
`timescale 1ns/1ps
`default_nettype none
module ctes_far (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    // Bench commands
    input  wire logic       lvl,
    input  wire logic       edge_sel,
    input  wire logic [7:0] lag,
    // Sequencer side
    input  wire logic       readout_start,
    output logic            trigger_in,
    output logic            readout_done
);
    logic [7:0] cnt_reg;

    // Active sense follows polarity; the bench sets the pulse width
    assign trigger_in   = edge_sel ? lvl : ~lvl;
    // Readout finishes lag cycles after its start pulse
    assign readout_done = (cnt_reg == 8'h01);

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            cnt_reg <= 8'h00;
        end else if (readout_start) begin
            cnt_reg <= lag;
        end else if (cnt_reg != 8'h00) begin
            cnt_reg <= cnt_reg - 8'h01;
        end
    end
endmodule
`default_nettype wire

// file: sim/ctes_seq_tb.sv
// Self-checking bench for the trigger and exposure sequencer
`timescale 1ns/1ps
`default_nettype none
module ctes_seq_tb;
    typedef struct {int len; logic [1:0] mode; int idx;} ctes_note_t;
    logic        clk_sys, resetn, cap, halt, lvl, edge_sel, trigger_in, readout_done;
    logic        readout_start, exposure_active, busy, trig_ign;
    logic [1:0]  mode_sel, active_mode;
    logic [15:0] fpe, frame_count;
    logic [31:0] exp_cyc, intv;
    logic [7:0]  lag;
    ctes_note_t  notes[$];
    ctes_note_t  nt;
    int          mismatches, total_checks, len, ign_seen, ign_exp;

    ctes_seq dut_u (.clk_sys(clk_sys), .resetn(resetn),
        .external_event_mode_select(mode_sel), .external_event_edge_select(edge_sel),
        .frames_per_event(fpe), .exposure_cycles(exp_cyc), .frame_interval_cycles(intv),
        .capture_start(cap), .acquisition_halt(halt), .trigger_in(trigger_in),
        .readout_done(readout_done), .readout_start(readout_start),
        .exposure_active(exposure_active), .acquisition_busy(busy),
        .trigger_ignored(trig_ign), .frame_count(frame_count), .active_mode(active_mode));

    ctes_far far_u (.clk_sys(clk_sys), .resetn(resetn), .lvl(lvl), .edge_sel(edge_sel),
        .lag(lag), .readout_start(readout_start), .trigger_in(trigger_in),
        .readout_done(readout_done));

    // ---------------------------------------------------------------
    // Checking helpers
    // ---------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] want);
        total_checks++;
        if (seen !== want) begin
            mismatches++;
            $display("BAD %s expected %0h seen %0h", what, want, seen);
        end
    endtask

    task automatic wrap_up();
        if (mismatches == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic clk(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    task automatic wait_rs();
        int i;
        for (i = 0; i < 200 && readout_start !== 1'b1; i++) @(negedge clk_sys);
        chk("readout_start", readout_start, 1);
    endtask

    task automatic wait_idle();
        int i;
        for (i = 0; i < 500 && busy !== 1'b0; i++) @(negedge clk_sys);
        chk("busy", busy, 0);
    endtask

    // One hardware-triggered frame, with a dropped edge during its readout
    task automatic shot(input int want, input int w, input logic [1:0] am);
        notes.push_back('{want, am, 1});
        lvl = 1'b1;
        clk(w);
        lvl = 1'b0;
        wait_rs();
        lvl = 1'b1;
        ign_exp++;
        wait_idle();
        clk(4);
        chk("still_idle", busy, 0);
        lvl = 1'b0;
        clk(2);
    endtask

    // ---------------------------------------------------------------
    // Monitor: exposure length and frame results against the notes
    // ---------------------------------------------------------------
    always @(negedge clk_sys) begin
        if (resetn === 1'b1) begin
            if (exposure_active === 1'b1) len++;
            if (trig_ign === 1'b1) ign_seen++;
            if (readout_start === 1'b1) begin
                if (notes.size() == 0) begin
                    chk("spare_frame", 1, 0);
                end else begin
                    nt = notes.pop_front();
                    chk("exposure_len", len, nt.len);
                    chk("active_mode", active_mode, nt.mode);
                    chk("frame_count", frame_count, nt.idx);
                end
                len = 0;
            end
        end
    end

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // Whole run is a few hundred cycles
    initial begin
        #(50 * 20000);
        mismatches++;
        wrap_up();
    end

    // ---------------------------------------------------------------
    // Stimulus
    // ---------------------------------------------------------------
    initial begin
        int k, i, e, w;
        resetn = 1'b0; cap = 1'b0; halt = 1'b0; lvl = 1'b0; edge_sel = 1'b0;
        mode_sel = 2'h0; fpe = 16'h0001; exp_cyc = 32'h1; intv = 32'h1; lag = 8'h02;
        mismatches = 0; total_checks = 0; len = 0; ign_seen = 0; ign_exp = 0;
        void'($urandom(65));
        clk(3);
        resetn = 1'b1;
        clk(1);
        // Async then level-timed, both polarities; zero exposure acts as one
        for (k = 0; k < 2; k++) begin
            edge_sel = k[0];
            lag = 8'(2 + $urandom % 6);
            mode_sel = 2'h1;
            fpe = 16'h0001;
            e = $urandom % 6;
            exp_cyc = 32'(e);
            shot(e == 0 ? 1 : e, 1, 2'h2);
            mode_sel = 2'h2;
            w = 2 + $urandom % 6;
            shot(w, w, 2'h3);
        end
        // Streaming with count zero: one trigger, free-running frames
        mode_sel = 2'h1; fpe = 16'h0000; exp_cyc = 32'h2; intv = 32'h1E;
        for (k = 1; k <= 3; k++) notes.push_back('{2, 2'h1, k});
        lvl = 1'b1;
        clk(1);
        lvl = 1'b0;
        clk(4);
        lvl = 1'b1;
        ign_exp++;
        for (i = 0; i < 300 && notes.size() != 0; i++) clk(1);
        halt = 1'b1;
        clk(1);
        halt = 1'b0;
        clk(1);
        chk("halted", busy, 0);
        lvl = 1'b0;
        // Let the cut readout drain so its done pulse cannot meet the next frame
        clk(8);
        // Software capture of three frames
        mode_sel = 2'h0; fpe = 16'h0003; intv = 32'h14;
        e = 1 + $urandom % 6;
        exp_cyc = 32'(e);
        for (k = 1; k <= 3; k++) notes.push_back('{e, 2'h0, k});
        cap = 1'b1;
        clk(1);
        cap = 1'b0;
        clk(1);
        wait_idle();
        chk("sw_frames", frame_count, 3);
        chk("ignored", ign_seen, ign_exp);
        chk("notes_left", notes.size(), 0);
        wrap_up();
    end
endmodule
`default_nettype wire
